/* File: stm_timer.sv */
/*
  stm_timer: 16-bit standard timer unit with compare, pwm, single pulse
  and timer modes, byte register port and one output pin.
  assumes inputs synchronous to i_clk_sys; the subsidiary clock arrives
  as a one-cycle enable pulse; the capture datapath lives elsewhere.
*/
// Overview of operation
// (RULE1) counter clears to zero when the on bit rises
// (RULE2) counter keeps its value when the on bit falls
// (RULE3) with the on bit low the counter does not advance
// (RULE4) output modes reload the initial pin level on an on-bit rise
// (RULE5) control zero bits two to zero read as zero
// (RULE6) two-bit mode: compare, capture, pwm or single pulse, timer
// (RULE7) software should stop the timer before changing mode
// (RULE8) compare mode A match: keep, low, high or toggle the pin
// (RULE9) pwm modes: inactive, active, pwm wave or single pulse
// (RULE10) capture mode edge: rising, falling, both, disabled
// (RULE11) match requesting the initial level gives no visible change
// (RULE12) software changes pin function in pwm mode only while stopped
// (RULE13) output-control bit sets initial or active level
// (RULE14) invert bit flips the pin, not in timer mode; the code does not flip it in capture mode either
// (RULE15) swap bit exchanges period and duty roles of A and P
// (RULE16) clear select: A match, or P match, or overflow when P zero
// (RULE17) clear select ignored in pwm, pulse and capture modes
// (RULE18) counter readable as two bytes, not writable, resets zero
// (RULE19) compare A is 16-bit read/write, reset zero, full compare
// (RULE20) compare P matches counter bits 15 to 8, period P times 256
// (RULE21) pause bit freezes the counter, resume without reset
// (RULE22) three-bit clock select of internal, sub and external edges
// (RULE23) low bytes pass a shared buffer tied to high byte access
// (RULE24) compare flags A and P; no P flag with clear select high
// (RULE25) counter advances once per timer tick while on and running
`timescale 1ns/1ps
module stm_timer #(
  parameter int HDIV_BASE = 1 // system ticks per high clock tick
) (
  input wire logic i_clk_sys, // 250 MHz system clock
  input wire logic i_rst_b, // async reset, active low
  input wire stm_pkg::stm_req_type i_req, // register port request
  output logic [7:0] o_rdata, // read data, cycle after read strobe
  input wire logic i_sub_tick, // subsidiary clock enable pulse
  input wire logic i_ext_clk, // external clock pin level
  input wire logic i_capture_in, // capture input pin level
  output logic o_capture_event, // selected capture edge seen
  output logic o_pin_out, // timer output pin
  output logic o_pin_oe_b, // pin output enable, low drives
  output logic o_flag_a, // compare A flag, sticky
  output logic o_flag_p // compare P flag, sticky
);
  // the base divider counts in 16 bits, so larger ratios cannot be served
  if (HDIV_BASE < 1 || HDIV_BASE > 65536) begin : g_bad_hdiv
    $error("HDIV_BASE must lie between 1 and 65536");
  end

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [7:0] cmpp_q;
  logic [7:0] lo_buf_q;
  logic on_prev_q;
  logic ext_prev_q;
  logic cap_prev_q;
  logic pin_q;
  logic pulse_arm_q;
  logic [1:0] flags_q;
  logic [5:0] div_q;
  logic [15:0] hdiv_q;
  logic [7:0] rdata_q;

  // field decode
  wire logic on_bit = ctrl0_q[stm_pkg::C0_ON];
  wire logic pause_bit = ctrl0_q[stm_pkg::C0_PAUSE];
  stm_pkg::stm_cksel_type cksel;
  stm_pkg::stm_mode_type mode;
  assign cksel = stm_pkg::stm_cksel_type'(
    ctrl0_q[stm_pkg::C0_CKSEL_HI:stm_pkg::C0_CKSEL_LO]);
  assign mode = stm_pkg::stm_mode_type'(
    ctrl1_q[stm_pkg::C1_MODE_HI:stm_pkg::C1_MODE_LO]); // RULE6
  wire logic [1:0] pinf = ctrl1_q[stm_pkg::C1_PINF_HI:stm_pkg::C1_PINF_LO];
  wire logic oc_bit = ctrl1_q[stm_pkg::C1_OC];
  wire logic pol_bit = ctrl1_q[stm_pkg::C1_POL];
  wire logic dpx_bit = ctrl1_q[stm_pkg::C1_DPX];
  wire logic cclr_bit = ctrl1_q[stm_pkg::C1_CCLR];
  wire logic on_rise = on_bit && !on_prev_q;

  // bus decode
  wire logic wr = i_req.wr;
  wire logic rd = i_req.rd;
  wire logic [2:0] ad = i_req.addr;

  // tick dividers for the internal prescaled clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 6'h0;
    end else if (hdiv_q == 16'h0000) begin
      div_q <= div_q + 6'h1;
    end
  end

  // base divider that turns the system clock into the high clock rate
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hdiv_q <= 16'h0000;
    end else if (hdiv_q == 16'(HDIV_BASE - 1)) begin
      hdiv_q <= 16'h0000;
    end else begin
      hdiv_q <= hdiv_q + 16'h0001;
    end
  end

  // sys/4 uses its own count off the system clock, not the high clock
  logic [1:0] s4_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s4_q <= 2'h0;
    end else begin
      s4_q <= s4_q + 2'h1;
    end
  end

  // timer tick selection
  logic tick;
  always_comb begin
    tick = 1'b0;
    unique case (cksel) // RULE22
      stm_pkg::STM_CK_SYS4: tick = (s4_q == 2'(stm_pkg::DIV_SYS4 - 1));
      stm_pkg::STM_CK_SYS: tick = 1'b1;
      stm_pkg::STM_CK_H16: tick = (hdiv_q == 16'h0000) &&
        (div_q[3:0] == 4'(stm_pkg::DIV_H16 - 1));
      stm_pkg::STM_CK_H64: tick = (hdiv_q == 16'h0000) &&
        (div_q == 6'(stm_pkg::DIV_H64 - 1));
      stm_pkg::STM_CK_SUB0, stm_pkg::STM_CK_SUB1: tick = i_sub_tick;
      stm_pkg::STM_CK_EXT_RISE: tick = i_ext_clk && !ext_prev_q;
      stm_pkg::STM_CK_EXT_FALL: tick = !i_ext_clk && ext_prev_q;
    endcase
  end

  // edge history of on bit and pins
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      on_prev_q <= on_bit;
      ext_prev_q <= i_ext_clk;
      cap_prev_q <= i_capture_in;
    end
  end

  // comparators on the next count
  wire logic run = on_bit && !pause_bit && tick; // RULE3 RULE21 RULE25
  wire logic match_a = run && (cnt_q + 16'h0001 == cmpa_q); // RULE19
  wire logic match_p = run && (cnt_q[15:8] + 8'h01 == cmpp_q) &&
    (cnt_q[7:0] == 8'hFF); // RULE20
  wire logic ovf = run && (cnt_q == 16'hFFFF);
  wire logic out_mode = (mode == stm_pkg::STM_MODE_CMP) ||
    (mode == stm_pkg::STM_MODE_PWM);

  // counter clear source
  logic clr;
  always_comb begin
    clr = 1'b0;
    if (mode == stm_pkg::STM_MODE_PWM) begin
      clr = dpx_bit ? match_a : (match_p || ovf); // RULE15 RULE17
    end else if (mode == stm_pkg::STM_MODE_CAP) begin
      clr = ovf; // RULE17
    end else begin
      clr = cclr_bit ? match_a : (match_p || ovf); // RULE16
    end
  end

  // the counter itself
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= stm_pkg::CNT_RESET; // RULE18
    end else if (on_rise) begin
      cnt_q <= 16'h0000; // RULE1
    end else if (clr) begin
      cnt_q <= 16'h0000;
    end else if (run) begin
      cnt_q <= cnt_q + 16'h0001; // RULE25
    end
    // with the on bit low nothing above fires, so the value holds RULE2
  end

  // compare flags; hardware set wins over software clear
  wire logic set_a = match_a && (cmpa_q != 16'h0000);
  wire logic set_p = match_p && !(cclr_bit &&
    mode != stm_pkg::STM_MODE_PWM); // RULE24
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= 2'b00;
    end else begin
      if (set_a) begin
        flags_q[stm_pkg::FL_A] <= 1'b1; // RULE24
      end else if (wr && ad == stm_pkg::ADDR_FLAGS &&
          i_req.wdata[stm_pkg::FL_A]) begin
        flags_q[stm_pkg::FL_A] <= 1'b0;
      end
      if (set_p) begin
        flags_q[stm_pkg::FL_P] <= 1'b1;
      end else if (wr && ad == stm_pkg::ADDR_FLAGS &&
          i_req.wdata[stm_pkg::FL_P]) begin
        flags_q[stm_pkg::FL_P] <= 1'b0;
      end
    end
  end

  // pwm duty comparison; count at or above duty is inactive, except with swap set and P zero, which is always active
  wire logic [15:0] duty_val = dpx_bit ? {cmpp_q, 8'h00} : cmpa_q; // RULE15
  wire logic pwm_active = (dpx_bit && cmpp_q == 8'h00) ||
    (cnt_q < duty_val);

  // raw pin level before inversion
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 1'b0;
      pulse_arm_q <= 1'b0;
    end else if (on_rise && out_mode) begin
      // forced-active and single pulse start at the active level, so a
      // restart does not glitch the pin to inactive for one cycle
      pin_q <= (mode == stm_pkg::STM_MODE_PWM && !pinf[0]) ?
        !oc_bit : oc_bit; // RULE4
      pulse_arm_q <= 1'b1;
    end else if (mode == stm_pkg::STM_MODE_CMP) begin
      if (set_a) begin
        unique case (pinf) // RULE8 RULE11
          2'b00: pin_q <= pin_q;
          2'b01: pin_q <= 1'b0;
          2'b10: pin_q <= 1'b1;
          2'b11: pin_q <= !pin_q;
        endcase
      end
    end else if (mode == stm_pkg::STM_MODE_PWM) begin
      unique case (pinf) // RULE9 RULE13
        2'b00: pin_q <= !oc_bit;
        2'b01: pin_q <= oc_bit;
        2'b10: pin_q <= on_bit && pwm_active ? oc_bit : !oc_bit;
        2'b11: begin
          if (!on_bit || match_a) begin
            pulse_arm_q <= 1'b0;
            pin_q <= !oc_bit;
          end else begin
            pin_q <= pulse_arm_q ? oc_bit : !oc_bit;
          end
        end
      endcase
    end
  end

  // capture edge detection
  always_comb begin
    o_capture_event = 1'b0;
    if (mode == stm_pkg::STM_MODE_CAP && on_bit) begin
      unique case (pinf) // RULE10
        2'b00: o_capture_event = i_capture_in && !cap_prev_q;
        2'b01: o_capture_event = !i_capture_in && cap_prev_q;
        2'b10: o_capture_event = i_capture_in != cap_prev_q;
        2'b11: o_capture_event = 1'b0;
      endcase
    end
  end

  // output stage; timer mode leaves the pin undriven
  assign o_pin_out = pin_q ^ (pol_bit && out_mode); // RULE14
  assign o_pin_oe_b = !out_mode;
  assign o_flag_a = flags_q[stm_pkg::FL_A];
  assign o_flag_p = flags_q[stm_pkg::FL_P];

  // register writes; the low byte buffer is shared for both pairs
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl0_q <= stm_pkg::CTRL_RESET;
      ctrl1_q <= stm_pkg::CTRL_RESET;
      cmpa_q <= stm_pkg::CMPA_RESET;
      cmpp_q <= stm_pkg::CMPP_RESET;
      lo_buf_q <= 8'h00;
    end else if (wr) begin
      unique case (ad)
        stm_pkg::ADDR_CTRL0:
          ctrl0_q <= i_req.wdata & stm_pkg::C0_IMPL_MASK; // RULE5
        stm_pkg::ADDR_CTRL1: ctrl1_q <= i_req.wdata;
        stm_pkg::ADDR_CMPA_LO: lo_buf_q <= i_req.wdata; // RULE23
        stm_pkg::ADDR_CMPA_HI: cmpa_q <= {i_req.wdata, lo_buf_q}; // RULE23
        stm_pkg::ADDR_CMPP: cmpp_q <= i_req.wdata;
        default: ;
      endcase
    end else if (rd) begin
      if (ad == stm_pkg::ADDR_CNT_HI) begin
        lo_buf_q <= cnt_q[7:0]; // RULE23
      end else if (ad == stm_pkg::ADDR_CMPA_HI) begin
        lo_buf_q <= cmpa_q[7:0];
      end
    end
  end

  // read data, registered for the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (ad)
        stm_pkg::ADDR_CTRL0: rdata_q <= ctrl0_q & stm_pkg::C0_IMPL_MASK;
        stm_pkg::ADDR_CTRL1: rdata_q <= ctrl1_q;
        stm_pkg::ADDR_CNT_LO: rdata_q <= lo_buf_q;
        stm_pkg::ADDR_CNT_HI: rdata_q <= cnt_q[15:8]; // RULE18
        stm_pkg::ADDR_CMPA_LO: rdata_q <= lo_buf_q;
        stm_pkg::ADDR_CMPA_HI: rdata_q <= cmpa_q[15:8];
        stm_pkg::ADDR_CMPP: rdata_q <= cmpp_q;
        stm_pkg::ADDR_FLAGS: rdata_q <= {6'h00, flags_q};
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  // checks
  a_on_rise_clear: assert property (@(posedge i_clk_sys) // RULE1
    disable iff (!i_rst_b) on_rise |=> cnt_q == 16'h0000)
    else $error("counter not cleared on enable");
  a_off_hold: assert property (@(posedge i_clk_sys) // RULE2
    disable iff (!i_rst_b) !on_bit ##1 !on_bit |-> $stable(cnt_q))
    else $error("counter moved while off");
  a_pause_freeze: assert property (@(posedge i_clk_sys) // RULE21
    disable iff (!i_rst_b) (pause_bit && !on_rise) |=> $stable(cnt_q))
    else $error("counter moved while paused");
  a_ctrl0_low_zero: assert property (@(posedge i_clk_sys) // RULE5
    disable iff (!i_rst_b) ctrl0_q[2:0] == 3'b000)
    else $error("unimplemented bits set");
  a_init_level: assert property (@(posedge i_clk_sys) // RULE4
    disable iff (!i_rst_b) (on_rise && mode == stm_pkg::STM_MODE_CMP)
    |=> pin_q == $past(oc_bit))
    else $error("initial level not loaded");
  a_flag_a_set: assert property (@(posedge i_clk_sys) // RULE24
    disable iff (!i_rst_b) set_a |=> o_flag_a)
    else $error("flag A missed");
  a_flag_p_set: assert property (@(posedge i_clk_sys) // RULE24
    disable iff (!i_rst_b) set_p |=> o_flag_p)
    else $error("flag P missed");
  // software can only clear flags, so any P flag appearing here is wrong
  a_no_p_flag: assert property (@(posedge i_clk_sys) // RULE24
    disable iff (!i_rst_b) (mode == stm_pkg::STM_MODE_CMP && cclr_bit &&
    !o_flag_p) |=> !o_flag_p)
    else $error("P flag with clear select high");
  a_high_latch: assert property (@(posedge i_clk_sys) // RULE23
    disable iff (!i_rst_b) (wr && ad == stm_pkg::ADDR_CMPA_HI)
    |=> cmpa_q == {$past(i_req.wdata), $past(lo_buf_q)})
    else $error("compare A pair not latched");
  a_cnt_step: assert property (@(posedge i_clk_sys) // RULE25
    disable iff (!i_rst_b) (run && !clr && !on_rise)
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step");
  a_p_clear: assert property (@(posedge i_clk_sys) // RULE16
    disable iff (!i_rst_b) (match_p && !cclr_bit && !on_rise &&
    mode == stm_pkg::STM_MODE_CMP) |=> cnt_q == 16'h0000)
    else $error("P match did not clear the counter");
  a_cnt_readonly: assert property (@(posedge i_clk_sys) // RULE18
    disable iff (!i_rst_b) (wr && !run && !on_rise &&
    (ad == stm_pkg::ADDR_CNT_LO || ad == stm_pkg::ADDR_CNT_HI))
    |=> $stable(cnt_q))
    else $error("counter written from the bus");
  a_pwm_forced: assert property (@(posedge i_clk_sys) // RULE9
    disable iff (!i_rst_b) (mode == stm_pkg::STM_MODE_PWM &&
    pinf == 2'b01) |=> pin_q == $past(oc_bit))
    else $error("forced active level not held");
  a_pulse_end: assert property (@(posedge i_clk_sys) // RULE9
    disable iff (!i_rst_b) (mode == stm_pkg::STM_MODE_PWM &&
    pinf == 2'b11 && match_a && !on_rise) |=> pin_q == !$past(oc_bit))
    else $error("single pulse did not end on A match");
  c_match_a: cover property (@(posedge i_clk_sys) set_a);
  c_match_p: cover property (@(posedge i_clk_sys) set_p);
  c_pwm_run: cover property (@(posedge i_clk_sys)
    mode == stm_pkg::STM_MODE_PWM && pinf == 2'b10 && clr);
  c_single_pulse: cover property (@(posedge i_clk_sys)
    mode == stm_pkg::STM_MODE_PWM && pinf == 2'b11 && match_a);
endmodule : stm_timer

/* File: stm_pkg.sv */
/*
  stm_pkg: shared constants and types of the standard timer unit.
  assumes a byte-wide register port and one 250 MHz system clock.
*/
package stm_pkg;
  // register indices on the byte port
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_CMPP = 3'h6;
  localparam logic [2:0] ADDR_FLAGS = 3'h7;
  // control zero field positions
  localparam int C0_PAUSE = 7;
  localparam int C0_CKSEL_HI = 6;
  localparam int C0_CKSEL_LO = 4;
  localparam int C0_ON = 3;
  localparam logic [7:0] C0_IMPL_MASK = 8'hF8;
  // control one field positions
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_PINF_HI = 5;
  localparam int C1_PINF_LO = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_DPX = 1;
  localparam int C1_CCLR = 0;
  // flag register positions
  localparam int FL_A = 0;
  localparam int FL_P = 1;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMPA_RESET = 16'h0000;
  localparam logic [7:0] CMPP_RESET = 8'h00;
  // divider ratios of the internal clock choices
  localparam int DIV_SYS4 = 4;
  localparam int DIV_H16 = 16;
  localparam int DIV_H64 = 64;

  typedef enum logic [1:0] {
    STM_MODE_CMP, STM_MODE_CAP, STM_MODE_PWM, STM_MODE_TMR
  } stm_mode_type;

  typedef enum logic [2:0] {
    STM_CK_SYS4, STM_CK_SYS, STM_CK_H16, STM_CK_H64,
    STM_CK_SUB0, STM_CK_SUB1, STM_CK_EXT_RISE, STM_CK_EXT_FALL
  } stm_cksel_type;

  // register port request carried as one bundle
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stm_req_type;
endpackage : stm_pkg

/* File: standard_timer_module_control_tb.sv */
/*
  self-checking bench for stm_timer: byte port tasks, pin and flag checks.
  assumes the register indices of stm_pkg and a 250 MHz system clock.
*/
`timescale 1ns/1ps
module standard_timer_module_control_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  stm_pkg::stm_req_type req = '0;
  logic sub = 1'b0;
  logic ext = 1'b0;
  logic cap = 1'b0;
  logic [7:0] rdata;
  logic cap_ev, pin, oe_b, fa, fp, e;
  logic [7:0] b;
  logic [15:0] c1, c2;
  logic [2:0] cks [4] = '{3'b100, 3'b101, 3'b110, 3'b111};
  logic [2:0] dcks [3] = '{3'b000, 3'b010, 3'b011};
  logic [15:0] dexp [3] = '{16'(256 / stm_pkg::DIV_SYS4),
    16'(256 / stm_pkg::DIV_H16), 16'(256 / stm_pkg::DIV_H64)};
  logic [7:0] pwv [3] = '{8'h88, 8'h98, 8'h8C};
  int fail_count = 0;
  int checks = 0;
  int n;

  stm_timer uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_req(req),
    .o_rdata(rdata), .i_sub_tick(sub), .i_ext_clk(ext),
    .i_capture_in(cap), .o_capture_event(cap_ev), .o_pin_out(pin),
    .o_pin_oe_b(oe_b), .o_flag_a(fa), .o_flag_p(fp));

  // free-running system clock, 4 ns period
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_clk_sys);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge i_clk_sys);
    req.rd <= 1'b0;
    @(negedge i_clk_sys);
    d = rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] x);
    rd(a, b);
    check({8'h00, b}, {8'h00, x});
  endtask : rdc

  // high byte first so the low byte is captured coherently
  task automatic cnt(output logic [15:0] v);
    logic [7:0] h, l;
    rd(3'h3, h);
    rd(3'h2, l);
    v = {h, l};
  endtask : cnt

  task automatic tick(input int k);
    repeat (k) @(negedge i_clk_sys);
  endtask : tick

  task automatic wflag(input logic p, output int w);
    w = 0;
    while (((p ? fp : fa) !== 1'b1) && w < 400) begin
      @(negedge i_clk_sys);
      w++;
    end
    check(16'(w < 400), 16'd1);
  endtask : wflag

  task automatic hi(input int k, output int h);
    h = 0;
    repeat (k) begin
      @(negedge i_clk_sys);
      if (pin === 1'b1) h++;
    end
  endtask : hi

  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs well under 10k cycles
  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rdc(a[2:0], 8'h00);
    wr(3'h0, 8'hF7);
    rdc(3'h0, 8'hF0);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hA5);
    rdc(3'h1, 8'hA5);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h5A);
    wr(3'h3, 8'hA5);
    rdc(3'h3, 8'h00);
    rdc(3'h2, 8'h00);
    $display("test registers done");
    // run, stop, restart and pause on the system clock
    wr(3'h0, 8'h18);
    tick(50);
    wr(3'h0, 8'h10);
    cnt(c1);
    tick(10);
    cnt(c2);
    check(c2, c1);
    check(16'(c1 > 16'd40), 16'd1);
    wr(3'h0, 8'h18);
    wr(3'h0, 8'h10);
    cnt(c2);
    check(16'(c2 < 16'd8), 16'd1);
    wr(3'h0, 8'h18);
    tick(20);
    wr(3'h0, 8'h98);
    cnt(c1);
    tick(10);
    cnt(c2);
    check(c2, c1);
    wr(3'h0, 8'h18);
    wr(3'h0, 8'h10);
    cnt(c2);
    check(16'(c2 > c1 && c2 < c1 + 16'd8), 16'd1);
    $display("test counter done");
    // five events on subsidiary tick, external rise and external fall
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, {1'b0, cks[i], 4'h8});
      tick(3);
      repeat (5) begin
        @(posedge i_clk_sys);
        sub <= (i < 2);
        ext <= (i >= 2);
        @(posedge i_clk_sys);
        sub <= 1'b0;
        ext <= 1'b0;
        tick(3);
      end
      wr(3'h0, 8'h00);
      cnt(c1);
      check(c1, 16'd5);
    end
    // prescaled choices over 256 counting cycles; the high clock equals
    // the system clock while the base divider keeps its default
    for (int i = 0; i < 3; i++) begin
      wr(3'h0, {1'b0, dcks[i], 4'h8});
      tick(256);
      wr(3'h0, 8'h00);
      cnt(c1);
      check(c1, dexp[i]);
    end
    $display("test clock select done");
    // compare mode pin actions for both initial levels, A clears
    wr(3'h4, 8'h10);
    wr(3'h5, 8'h00);
    rdc(3'h5, 8'h00);
    rdc(3'h4, 8'h10);
    for (int oc = 0; oc < 2; oc++) begin
      for (int pf = 0; pf < 4; pf++) begin
        wr(3'h1, {2'b00, pf[1:0], oc[0], 3'b001});
        wr(3'h7, 8'h03);
        tick(1);
        check(16'(fa), 16'd0);
        wr(3'h0, 8'h18);
        tick(2);
        check(16'(pin), 16'(oc[0]));
        check(16'(oe_b), 16'd0);
        wflag(1'b0, n);
        tick(2);
        e = (pf == 0) ? oc[0] : (pf == 3) ? ~oc[0] : pf[1];
        check(16'(pin), 16'(e));
        check(16'(fp), 16'd0);
        wr(3'h0, 8'h00);
      end
    end
    wr(3'h1, 8'h05);
    wr(3'h0, 8'h18);
    tick(2);
    check(16'(pin), 16'd1);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hC5);
    tick(1);
    check(16'(oe_b), 16'd1);
    $display("test compare done");
    // forced pwm levels, then duty and period with and without swap
    for (int i = 0; i < 3; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, pwv[i]);
      wr(3'h0, 8'h18);
      tick(2);
      check(16'(pin), 16'(i != 0));
    end
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h1, 8'hA8);
    wr(3'h0, 8'h18);
    hi(256, n);
    check(16'(n), 16'd16);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h02);
    wr(3'h1, 8'hAA);
    wr(3'h0, 8'h18);
    hi(512, n);
    check(16'(n), 16'd256);
    $display("test pwm done");
    // comparator P clears the counter when clear select is low
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h5, 8'h00);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
    wflag(1'b1, n);
    check(16'(n >= 250 && n <= 262), 16'd1);
    rdc(3'h3, 8'h00);
    $display("test clear select done");
    // single pulse: active from the on-bit rise until compare A matches
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hB8);
    wr(3'h0, 8'h18);
    hi(64, n);
    check(16'(n), 16'h0010);
    $display("test single pulse done");
    // capture edge choices: rising, falling, both, disabled
    for (int pf = 0; pf < 4; pf++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, {2'b01, pf[1:0], 4'h0});
      wr(3'h0, 8'h18);
      n = 0;
      for (int k = 0; k < 14; k++) begin
        @(posedge i_clk_sys);
        cap <= (k >= 2 && k < 7);
        @(negedge i_clk_sys);
        if (cap_ev === 1'b1) n++;
      end
      check(16'(n), (pf == 2) ? 16'd2 : (pf == 3) ? 16'd0 : 16'd1);
    end
    $display("test capture done");
    summarize();
  end
endmodule : standard_timer_module_control_tb
